// *** include/lsu_pkg.sv ***
// Constants and types for the load/store transfer unit
package lsu_pkg;
  localparam int          ADDR_W         = 8;
  // Register byte offsets
  localparam logic [7:0]  REG_CTRL       = 8'h00;
  localparam logic [7:0]  REG_BASE       = 8'h04;
  localparam logic [7:0]  REG_OFFSET     = 8'h08;
  localparam logic [7:0]  REG_SDATA      = 8'h0C;
  localparam logic [7:0]  REG_PC         = 8'h10;
  localparam logic [7:0]  REG_CACHE      = 8'h14;
  localparam logic [7:0]  REG_STATUS     = 8'h18;
  localparam logic [7:0]  REG_RESULT     = 8'h1C;
  localparam logic [7:0]  REG_NEWBASE    = 8'h20;
  localparam logic [7:0]  REG_XADDR      = 8'h24;
  // Control register bits
  localparam int          CB_START       = 0;
  localparam int          CB_LOAD        = 1;
  localparam int          CB_BYTE        = 2;
  localparam int          CB_PRE         = 3;
  localparam int          CB_UP          = 4;
  localparam int          CB_WB          = 5;
  localparam int          CB_IMM         = 6;
  localparam int          CB_BASE_PC     = 7;
  localparam int          CB_OFF_PC      = 8;
  localparam int          CB_RD_PC       = 9;
  localparam int          CB_USER        = 10;
  localparam int          CTRL_W         = 11;
  // Cache control bits
  localparam int          CC_EN          = 0;
  localparam int          CC_INVAL       = 1;
  localparam int          CC_SUP_LO      = 8;
  localparam int          CC_W           = 16;
  // Status bits
  localparam int          SB_BUSY        = 0;
  localparam int          SB_DONE        = 1;
  localparam int          SB_ADDR_EXC    = 2;
  localparam int          SB_ABORT       = 3;
  localparam int          SB_HIT         = 4;
  // Program counter layout and pipeline advance
  localparam logic [31:0] PC_MASK        = 32'h03FF_FFFC;
  localparam logic [31:0] PC_AHEAD_BASE  = 32'h0000_0008;
  localparam logic [31:0] PC_AHEAD_STORE = 32'h0000_000C;
  localparam int          LEGAL_TOP      = 25;
  // Cache geometry: 8 direct-mapped words
  localparam int          C_ENTRIES      = 8;
  localparam int          C_IDX_LO       = 2;
  localparam int          C_TAG_LO       = 5;
  localparam int          C_TAG_W        = 21;
  localparam int          C_REGION_LO    = 23;
  localparam logic [1:0]  RESP_OKAY      = 2'h0;
  localparam logic [1:0]  RESP_SLVERR    = 2'h2;

  typedef enum logic [2:0] {
    LSU_IDLE = 3'b001,
    LSU_CALC = 3'b010,
    LSU_MEM  = 3'b100
  } lsu_state_e_t;
endpackage

// *** logic/lsu_top.sv ***
// Load/store transfer unit with AXI4-Lite registers, data cache and memory port
//
// The register offsets and register access over AXI4-Lite were decided locally.
`timescale 1ns/10ps
module lsu_top
  import lsu_pkg::*;
(
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic              ce,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  output logic                   mem_req,
  output logic                   mem_we,
  output logic                   mem_byte,
  output logic [31:0]            mem_addr,
  output logic [31:0]            mem_wdata,
  output logic                   user_translate_n,
  input  wire logic [31:0]       mem_rdata,
  input  wire logic              mem_ack,
  input  wire logic              mem_abort,
  output logic                   trap_addr_exc,
  output logic                   trap_data_abort
);

  typedef struct packed {
    lsu_state_e_t                         st;
    logic                                 aw_ok;
    logic [ADDR_W-1:0]                    aw_addr;
    logic                                 w_ok;
    logic [31:0]                          w_data;
    logic [3:0]                           w_store_byte_op;
    logic                                 awready;
    logic                                 wready;
    logic                                 bvalid;
    logic [1:0]                           bresp;
    logic                                 arready;
    logic                                 rvalid;
    logic [31:0]                          rdata;
    logic [1:0]                           rresp;
    logic [CTRL_W-1:0]                    ctrl;
    logic [31:0]                          base;
    logic [31:0]                          offset;
    logic [31:0]                          sdata;
    logic [31:0]                          pcpsr;
    logic [CC_W-1:0]                      cctrl;
    logic [4:0]                           status;
    logic [31:0]                          result;
    logic [31:0]                          newbase;
    logic [31:0]                          xaddr;
    logic                                 mem_req;
    logic                                 mem_we;
    logic                                 mem_byte;
    logic [31:0]                          mem_wdata;
    logic                                 user_translate_n_n;
    logic                                 trap_exc;
    logic                                 trap_abt;
    logic [C_ENTRIES-1:0]                 cvalid;
    logic [C_ENTRIES-1:0][C_TAG_W-1:0]    ctag;
    logic [C_ENTRIES-1:0][31:0]           cdata;
  } lsu_regs_t;

  lsu_regs_t s;
  lsu_regs_t n;

  logic [31:0] pc_bits;
  logic [31:0] flags;
  logic [31:0] base_v;
  logic [31:0] off_v;
  logic [31:0] mod_v;
  logic [31:0] addr_v;
  logic [31:0] store_v;
  logic [31:0] caddr;
  logic [2:0]  cidx;
  logic        chit;
  logic        sup;
  logic [31:0] ld_v;
  logic        wb;
  logic [31:0] wmrg;

  // Merge write data under byte strobes
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0]  store_byte_op);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (store_byte_op[i]) begin
        r[8*i +: 8] = nw[8*i +: 8];
      end
    end
    return r;
  endfunction

  // Lane pick and rotation of loaded data
  function automatic logic [31:0] fmt_load(input logic [31:0] d,
                                           input logic [1:0]  a,
                                           input logic        is_byte);
    logic [63:0] rot;
    rot = {d, d} >> {a, 3'b000};
    return is_byte ? {24'h00_0000, rot[7:0]} : rot[31:0];
  endfunction

  always_comb begin
    wmrg    = 32'h0000_0000;
    // Operand formation
    pc_bits = s.pcpsr & PC_MASK;
    flags   = s.pcpsr & ~PC_MASK;
    base_v  = s.ctrl[CB_BASE_PC] ? ((pc_bits + PC_AHEAD_BASE) & PC_MASK) : s.base;
    if (s.ctrl[CB_IMM]) begin
      off_v = {20'h0_0000, s.offset[11:0]};
    end else if (s.ctrl[CB_OFF_PC]) begin
      off_v = ((pc_bits + PC_AHEAD_BASE) & PC_MASK) | flags;
    end else begin
      off_v = s.offset;
    end
    mod_v   = s.ctrl[CB_UP] ? base_v + off_v : base_v - off_v;
    addr_v  = s.ctrl[CB_PRE] ? mod_v : base_v;
    store_v = s.ctrl[CB_RD_PC] ? (((pc_bits + PC_AHEAD_STORE) & PC_MASK) | flags)
                               : s.sdata;
    wb      = !s.ctrl[CB_PRE] || s.ctrl[CB_WB];
    // Cache lookup
    caddr   = (s.st == LSU_CALC) ? addr_v : s.xaddr;
    cidx    = caddr[C_TAG_LO-1:C_IDX_LO];
    chit    = s.cvalid[cidx] && (s.ctag[cidx] == caddr[LEGAL_TOP:C_TAG_LO]);
    sup     = s.cctrl[CC_SUP_LO + 32'(caddr[LEGAL_TOP:C_REGION_LO])];
    ld_v    = fmt_load(chit && s.st == LSU_CALC ? s.cdata[cidx] : mem_rdata,
                       caddr[1:0], s.ctrl[CB_BYTE]);

    n          = s;
    n.trap_exc = 1'b0;
    n.trap_abt = 1'b0;

    // AXI write path
    if (s.bvalid && s_axi_bready) begin
      n.bvalid = 1'b0;
    end
    if (s.awready && s_axi_awvalid) begin
      n.aw_ok   = 1'b1;
      n.aw_addr = s_axi_awaddr;
    end
    if (s.wready && s_axi_wvalid) begin
      n.w_ok   = 1'b1;
      n.w_data = s_axi_wdata;
      n.w_store_byte_op = s_axi_wstrb;
    end
    if (s.aw_ok && s.w_ok && !n.bvalid) begin
      n.aw_ok  = 1'b0;
      n.w_ok   = 1'b0;
      n.bvalid = 1'b1;
      n.bresp  = RESP_OKAY;
      unique case ({s.aw_addr[ADDR_W-1:2], 2'b00})
        REG_CTRL: begin
          if (s.st == LSU_IDLE) begin
            wmrg   = merge({21'h0, s.ctrl}, s.w_data, s.w_store_byte_op);
            n.ctrl = wmrg[CTRL_W-1:0];
            if (n.ctrl[CB_START]) begin
              n.ctrl[CB_START] = 1'b0;
              n.status         = 5'h00;
              n.status[SB_BUSY] = 1'b1;
              n.st             = LSU_CALC;
            end
          end
        end
        REG_BASE:   n.base   = merge(s.base, s.w_data, s.w_store_byte_op);
        REG_OFFSET: n.offset = merge(s.offset, s.w_data, s.w_store_byte_op);
        REG_SDATA:  n.sdata  = merge(s.sdata, s.w_data, s.w_store_byte_op);
        REG_PC:     n.pcpsr  = merge(s.pcpsr, s.w_data, s.w_store_byte_op);
        REG_CACHE: begin
          wmrg    = merge({16'h0000, s.cctrl}, s.w_data, s.w_store_byte_op);
          n.cctrl = wmrg[CC_W-1:0];
          if (n.cctrl[CC_INVAL]) begin
            n.cvalid          = '0;
            n.cctrl[CC_INVAL] = 1'b0;
          end
        end
        REG_STATUS, REG_RESULT, REG_NEWBASE, REG_XADDR: ;
        default:    n.bresp  = RESP_SLVERR;
      endcase
    end
    // Ready stays low while a write waits or is answered
    n.awready = !n.aw_ok && !n.bvalid;
    n.wready  = !n.w_ok && !n.bvalid;

    // AXI read path
    if (s.rvalid && s_axi_rready) begin
      n.rvalid  = 1'b0;
      n.arready = 1'b1;
    end
    if (s.arready && s_axi_arvalid) begin
      n.arready = 1'b0;
      n.rvalid  = 1'b1;
      n.rresp   = RESP_OKAY;
      unique case ({s_axi_araddr[ADDR_W-1:2], 2'b00})
        REG_CTRL:    n.rdata = {21'h0, s.ctrl};
        REG_BASE:    n.rdata = s.base;
        REG_OFFSET:  n.rdata = s.offset;
        REG_SDATA:   n.rdata = s.sdata;
        REG_PC:      n.rdata = s.pcpsr;
        REG_CACHE:   n.rdata = {16'h0000, s.cctrl};
        REG_STATUS:  n.rdata = {27'h0, s.status};
        REG_RESULT:  n.rdata = s.result;
        REG_NEWBASE: n.rdata = s.newbase;
        REG_XADDR:   n.rdata = s.xaddr;
        default: begin
          n.rdata = 32'h0000_0000;
          n.rresp = RESP_SLVERR;
        end
      endcase
    end

    // Transfer sequencer
    unique case (s.st)
      LSU_IDLE: ;
      LSU_CALC: begin
        n.xaddr   = addr_v;
        n.newbase = mod_v;
        // Illegal high address bits stop the transfer here
        if (|addr_v[31:LEGAL_TOP+1]) begin
          n.status[SB_ADDR_EXC] = 1'b1;
          n.status[SB_DONE]     = 1'b1;
          n.status[SB_BUSY]     = 1'b0;
          n.trap_exc            = 1'b1;
          n.st                  = LSU_IDLE;
        end else if (s.ctrl[CB_LOAD] && s.cctrl[CC_EN] && chit) begin
          n.result           = ld_v;
          n.status[SB_HIT]   = 1'b1;
          n.status[SB_DONE]  = 1'b1;
          n.status[SB_BUSY]  = 1'b0;
          if (wb) begin
            if (s.ctrl[CB_BASE_PC]) begin
              n.pcpsr = (mod_v & PC_MASK) | flags;
            end else begin
              n.base = mod_v;
            end
          end
          if (s.ctrl[CB_RD_PC]) begin
            n.pcpsr = (ld_v & PC_MASK) | flags;
          end
          n.st = LSU_IDLE;
        end else begin
          n.mem_req   = 1'b1;
          n.mem_we    = !s.ctrl[CB_LOAD];
          n.mem_byte  = s.ctrl[CB_BYTE];
          n.mem_wdata = s.ctrl[CB_BYTE] ? {4{store_v[7:0]}} : store_v;
          n.user_translate_n_n   = !s.ctrl[CB_USER] &&
                        !(!s.ctrl[CB_PRE] && s.ctrl[CB_WB]);
          n.st        = LSU_MEM;
        end
      end
      LSU_MEM: begin
        // Abort wins over ack in the same cycle
        if (mem_abort) begin
          n.mem_req           = 1'b0;
          n.user_translate_n_n           = 1'b1;
          n.status[SB_ABORT]  = 1'b1;
          n.status[SB_DONE]   = 1'b1;
          n.status[SB_BUSY]   = 1'b0;
          n.trap_abt          = 1'b1;
          n.st                = LSU_IDLE;
        end else if (mem_ack) begin
          n.mem_req          = 1'b0;
          n.user_translate_n_n          = 1'b1;
          n.status[SB_DONE]  = 1'b1;
          n.status[SB_BUSY]  = 1'b0;
          if (wb) begin
            if (s.ctrl[CB_BASE_PC]) begin
              n.pcpsr = (s.newbase & PC_MASK) | flags;
            end else begin
              n.base = s.newbase;
            end
          end
          if (s.ctrl[CB_LOAD]) begin
            n.result = ld_v;
            // Loaded counter overrides a counter write-back
            if (s.ctrl[CB_RD_PC]) begin
              n.pcpsr = (ld_v & PC_MASK) | flags;
            end
            // Only aligned word loads fill the cache
            if (s.cctrl[CC_EN] && !s.ctrl[CB_BYTE] && s.xaddr[1:0] == 2'b00) begin
              n.cvalid[cidx] = 1'b1;
              n.ctag[cidx]   = s.xaddr[LEGAL_TOP:C_TAG_LO];
              n.cdata[cidx]  = mem_rdata;
            end
            // Store hit outside a suppressed region updates the cache even with reads off
          end else if (chit && !sup) begin
            if (s.mem_byte) begin
              n.cdata[cidx][8*s.xaddr[1:0] +: 8] = s.mem_wdata[7:0];
            end else begin
              n.cdata[cidx] = s.mem_wdata;
            end
          end
          n.st = LSU_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      // Ready outputs and translate pin idle high
      s         <= '0;
      s.st      <= LSU_IDLE;
      s.awready <= 1'b1;
      s.wready  <= 1'b1;
      s.arready <= 1'b1;
      s.user_translate_n_n <= 1'b1;
    end else if (ce) begin
      s <= n;
    end
  end

  assign s_axi_awready    = s.awready;
  assign s_axi_wready     = s.wready;
  assign s_axi_bvalid     = s.bvalid;
  assign s_axi_bresp      = s.bresp;
  assign s_axi_arready    = s.arready;
  assign s_axi_rvalid     = s.rvalid;
  assign s_axi_rdata      = s.rdata;
  assign s_axi_rresp      = s.rresp;
  assign mem_req          = s.mem_req;
  assign mem_we           = s.mem_we;
  assign mem_byte         = s.mem_byte;
  assign mem_addr         = s.xaddr;
  assign mem_wdata        = s.mem_wdata;
  assign user_translate_n = s.user_translate_n_n;
  assign trap_addr_exc    = s.trap_exc;
  assign trap_data_abort  = s.trap_abt;

endmodule

// *** tb/lsu_asserts.sv ***
// Concurrent checks on the memory port and trap outputs of the transfer unit
`timescale 1ns/10ps
module lsu_asserts
  import lsu_pkg::*;
(
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        ce,
  input wire logic        mem_req,
  input wire logic        mem_we,
  input wire logic        mem_byte,
  input wire logic [31:0] mem_addr,
  input wire logic [31:0] mem_wdata,
  input wire logic        mem_ack,
  input wire logic        mem_abort,
  input wire logic        trap_addr_exc,
  input wire logic        trap_data_abort
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_addr_legal: assert property (mem_req |-> mem_addr[31:26] == 6'h00)
    else $error("memory request to an address with high bits set");
  a_byte_fanout: assert property (mem_req && mem_we && mem_byte |->
    mem_wdata == {4{mem_wdata[7:0]}})
    else $error("byte store data not repeated on all lanes");
  a_req_held: assert property (ce && mem_req && !mem_ack && !mem_abort |=>
    mem_req && $stable(mem_addr) && $stable(mem_wdata) && $stable(mem_we))
    else $error("memory request dropped or changed before its answer");
  a_req_release: assert property (ce && mem_req && (mem_ack || mem_abort) |=> !mem_req)
    else $error("memory request still high after its answer");
  a_abort_trap: assert property (ce && mem_req && mem_abort |-> ##[1:2] trap_data_abort)
    else $error("abort did not raise the data abort trap");
  a_abort_pulse: assert property (ce && trap_data_abort |=> !trap_data_abort)
    else $error("data abort trap longer than one cycle");
  a_exc_pulse: assert property (ce && trap_addr_exc |=> !trap_addr_exc)
    else $error("address exception trap longer than one cycle");
  a_exc_no_req: assert property (trap_addr_exc |-> !mem_req ##1 !mem_req)
    else $error("memory request issued with an address exception");
endmodule

bind lsu_top lsu_asserts u_chk (.aclk(aclk), .aresetn(aresetn), .ce(ce), .mem_req(mem_req),
  .mem_we(mem_we), .mem_byte(mem_byte), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
  .mem_ack(mem_ack), .mem_abort(mem_abort), .trap_addr_exc(trap_addr_exc),
  .trap_data_abort(trap_data_abort));

// *** tb/lsu_mem_model.sv ***
// External memory and memory manager model for the transfer unit
`timescale 1ns/10ps
module lsu_mem_model
  import lsu_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        mem_req,
  input  wire logic        mem_we,
  input  wire logic        mem_byte,
  input  wire logic [31:0] mem_addr,
  input  wire logic [31:0] mem_wdata,
  input  wire logic        user_translate_n,
  input  wire logic [31:0] delay,
  input  wire logic        abort_en,
  output logic [31:0]      mem_rdata,
  output logic             mem_ack,
  output logic             mem_abort,
  output int               accesses,
  output logic             last_ut
);
  logic [31:0] mem [16];
  int          waited;
  logic        answered;
  initial begin
    mem_ack = 1'b0;
    mem_abort = 1'b0;
    mem_rdata = 32'h0;
    accesses = 0;
  end
  always @(posedge aclk) begin
    mem_ack   <= 1'b0;
    mem_abort <= 1'b0;
    mem_rdata <= ~mem_rdata;  // Bus not driven: junk
    if (!aresetn || !mem_req) begin
      waited   <= 0;
      answered <= 1'b0;
    end else if (!answered && waited < delay) begin
      waited <= waited + 1;
    end else if (!answered) begin
      answered <= 1'b1;
      accesses <= accesses + 1;
      last_ut  <= user_translate_n;
      if (abort_en) begin
        mem_abort <= 1'b1;
      end else begin
        mem_ack   <= 1'b1;
        mem_rdata <= mem[mem_addr[5:2]];
        for (int i = 0; i < 4; i++) begin
          if (mem_we && (!mem_byte || mem_addr[1:0] == i[1:0])) begin
            mem[mem_addr[5:2]][8*i+:8] <= mem_wdata[8*i+:8];
          end
        end
      end
    end
  end
endmodule

// *** tb/testbench.sv ***
// Register-level tests of the load/store transfer unit
`timescale 1ns/10ps
module testbench;
  import lsu_pkg::*;
  localparam logic [31:0] W0 = 32'h4433_2211;
  localparam logic [31:0] LD = 32'h1 << CB_LOAD, BY = 32'h1 << CB_BYTE, PR = 32'h1 << CB_PRE;
  localparam logic [31:0] UP = 32'h1 << CB_UP, WB = 32'h1 << CB_WB, IM = 32'h1 << CB_IMM;
  localparam logic [31:0] BPC = 32'h1 << CB_BASE_PC, OPC = 32'h1 << CB_OFF_PC;
  localparam logic [31:0] DPC = 32'h1 << CB_RD_PC;
  logic aclk, aresetn, ce, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic mem_req, mem_we, mem_byte, user_translate_n, mem_ack, mem_abort, abort_en, last_ut;
  logic trap_addr_exc, trap_data_abort;
  logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, mem_addr, mem_wdata, mem_rdata, v, st;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, last_resp;
  int delay, accesses, errors, checks_done, cyc, acc;

  lsu_top dut (.*);
  lsu_mem_model u_mem (.*);

  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    last_resp = s_axi_bresp;
  endtask
  task rd(input logic [7:0] a, output logic [31:0] d);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    last_resp = s_axi_rresp;
  endtask
  task run(input logic [31:0] ctrl, input logic [31:0] base, input logic [31:0] off);
    wr(REG_BASE, base);
    wr(REG_OFFSET, off);
    wr(REG_CTRL, ctrl | 32'h1);
    do rd(REG_STATUS, st); while (st[SB_BUSY] === 1'b1);
  endtask
  task results;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      results();
    end
  end

  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, abort_en} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {ce, s_axi_bready, s_axi_rready, s_axi_wstrb} = 7'h7F;
    delay = 3;
    for (int i = 0; i < 16; i++) u_mem.mem[i] = 32'h0;
    u_mem.mem[0] = W0;
    u_mem.mem[1] = 32'h8877_6655;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    for (int k = 0; k < 4; k++) begin
      run(LD | BY | PR | UP | IM, 0, k);
      rd(REG_RESULT, v);
      chk(v, {24'h0, W0[8*k+:8]});
      run(LD | PR | UP | IM, 0, k);
      rd(REG_RESULT, v);
      chk(v, (W0 >> (8 * k)) | (W0 << (32 - 8 * k)));
    end
    chk({31'h0, last_ut}, 32'h1);
    $display("loads done");
    delay <= 0;
    wr(REG_SDATA, 32'h0000_12AB);
    chk({30'h0, last_resp}, {30'h0, RESP_OKAY});
    run(BY | UP | IM, 9, 3);
    chk(u_mem.mem[2], 32'h0000_AB00);
    rd(REG_BASE, v);
    chk(v, 32'h0000_000C);
    chk({31'h0, last_ut}, 32'h1);
    run(BY | IM | WB, 32'hC, 4);
    chk(u_mem.mem[3], 32'h0000_00AB);
    rd(REG_BASE, v);
    chk(v, 32'h0000_0008);
    chk({31'h0, last_ut}, 32'h0);
    run(LD | PR | UP | IM | (32'h1 << CB_USER), 0, 0);
    chk({31'h0, last_ut}, 32'h0);
    $display("stores done");
    acc = accesses;
    run(LD | PR | UP | IM, 32'h0400_0000, 0);
    chk({31'h0, st[SB_ADDR_EXC]}, 32'h1);
    chk(accesses, acc);
    run(LD | PR, 32'h0400_0008, 32'h0400_0000);
    chk({31'h0, st[SB_ADDR_EXC]}, 32'h0);
    run(LD | UP, 0, 32'h0400_0000);
    chk({31'h0, st[SB_ADDR_EXC]}, 32'h0);
    rd(REG_BASE, v);
    chk(v, 32'h0400_0000);
    $display("address checks done");
    wr(REG_PC, 32'h0000_0023);
    wr(REG_SDATA, 32'h5A5A_5A5A);
    abort_en <= 1'b1;
    run(PR | UP | IM | WB, 32'h10, 4);
    abort_en <= 1'b0;
    chk({31'h0, st[SB_ABORT]}, 32'h1);
    rd(REG_BASE, v);
    chk(v, 32'h0000_0010);
    chk(u_mem.mem[5], 32'h0);
    run(LD | PR | UP | IM | BPC, 0, 0);
    rd(REG_XADDR, v);
    chk(v, 32'h0000_0028);
    run(LD | PR | UP | OPC, 0, 0);
    rd(REG_XADDR, v);
    chk(v, 32'h0000_002B);
    run(PR | UP | IM | DPC, 32'h30, 0);
    chk(u_mem.mem[12], 32'h0000_002F);
    rd(REG_PC, v);
    chk(v, 32'h0000_0023);
    run(LD | PR | UP | IM | DPC, 4, 0);
    rd(REG_PC, v);
    chk(v, 32'h0077_6657);
    $display("abort and counter done");
    wr(REG_CACHE, 32'h1);
    acc = accesses;
    run(LD | PR | UP | IM, 0, 0);
    chk(accesses, acc + 1);
    run(LD | PR | UP | IM, 0, 0);
    rd(REG_RESULT, v);
    chk(v, W0);
    chk({31'h0, st[SB_HIT]}, 32'h1);
    chk(accesses, acc + 1);
    wr(REG_CACHE, 32'h0);
    wr(REG_SDATA, 32'h0000_9999);
    run(PR | UP | IM, 0, 0);
    chk(accesses, acc + 2);
    wr(REG_CACHE, 32'h1);
    run(LD | PR | UP | IM, 0, 0);
    rd(REG_RESULT, v);
    chk(v, 32'h0000_9999);
    wr(REG_CACHE, 32'h100);
    wr(REG_SDATA, 32'h0000_5555);
    run(PR | UP | IM, 0, 0);
    wr(REG_CACHE, 32'h1);
    run(LD | PR | UP | IM, 0, 0);
    rd(REG_RESULT, v);
    chk(v, 32'h0000_9999);
    wr(REG_CACHE, 32'h0);
    run(LD | PR | UP | IM, 0, 0);
    rd(REG_RESULT, v);
    chk(v, 32'h0000_5555);
    rd(8'h30, v);
    chk({30'h0, last_resp}, {30'h0, RESP_SLVERR});
    wr(8'h30, 32'h1);
    chk({30'h0, last_resp}, {30'h0, RESP_SLVERR});
    wr(REG_CACHE, 32'h3);
    rd(REG_CACHE, v);
    chk(v, 32'h0000_0001);
    chk({30'h0, last_resp}, {30'h0, RESP_OKAY});
    acc = accesses;
    run(LD | PR | UP | IM, 0, 0);
    chk(accesses, acc + 1);
    rd(REG_RESULT, v);
    chk(v, 32'h0000_5555);
    $display("cache and bus done");
    results();
  end
endmodule
